// >>> design/aac_cfg.svh
`ifndef AAC_CFG_SVH
`define AAC_CFG_SVH

`define AAC_CLK_MHZ       50
`define AAC_WAKE_TIME_MS  3.5
`define AAC_WAKE_CYC      ($rtoi(`AAC_WAKE_TIME_MS * 1000.0 * `AAC_CLK_MHZ))
`define AAC_POWERUP_CYC   16
`define AAC_QTR_CYC       10

`define AAC_ID_TOP        6'h3e
`define AAC_BITS_PER_BYTE 4'h8

`define AAC_SEL_MODE_A    3'h0
`define AAC_SEL_MODE_B    3'h1
`define AAC_SEL_BOOST     3'h3
`define AAC_SEL_MVOL      3'h4
`define AAC_SEL_EXT       3'h5
`define AAC_SEL_LVOL      3'h6
`define AAC_SEL_RVOL      3'h7

`define AAC_BYP_BIT       3
`define AAC_GBM_BIT       2
`define AAC_GBL_BIT       1
`define AAC_GBR_BIT       0

`define AAC_MODE_RST      4'h0
`define AAC_VOL_RST       6'h00
`define AAC_FLAG_RST      1'h0
`define AAC_VOL_MAX       6'h28
`define AAC_BOOST_QDB     10'sh00c

`endif

// >>> design/aac_pkg.sv
`include "aac_cfg.svh"

package aac_pkg;

	typedef enum logic [2:0] {
		aac_idle     = 3'h0,
		aac_rx_id    = 3'h1,
		aac_ack_id   = 3'h3,
		aac_rx_byte  = 3'h2,
		aac_ack_byte = 3'h6,
		aac_ignore   = 3'h7
	} aac_dev_state_t;

	typedef enum logic [1:0] {
		aac_h_idle  = 2'h0,
		aac_h_start = 2'h1,
		aac_h_bits  = 2'h3,
		aac_h_stop  = 2'h2
	} aac_host_state_t;

	typedef struct packed {
		logic spk_mono;
		logic spk_stereo;
		logic hp_mono;
		logic hp_stereo;
	} aac_route_t;

	// gain in quarter dB steps, signed
	typedef logic signed [9:0] aac_gain_t;

	localparam aac_gain_t AAC_GAIN_QDB [41] = '{
		-10'sd328, -10'sd304, -10'sd280, -10'sd258, -10'sd234, -10'sd208, -10'sd186,
		-10'sd162, -10'sd138, -10'sd120, -10'sd106, -10'sd96, -10'sd84, -10'sd72,
		-10'sd60, -10'sd54, -10'sd46, -10'sd40, -10'sd34, -10'sd28, -10'sd24,
		-10'sd18, -10'sd12, -10'sd6, 10'sd0, 10'sd6, 10'sd12, 10'sd18,
		10'sd24, 10'sd30, 10'sd36, 10'sd42, 10'sd48, 10'sd51, 10'sd54,
		10'sd57, 10'sd60, 10'sd63, 10'sd66, 10'sd69, 10'sd72
	};

	function automatic aac_route_t aac_route_decode(input logic [3:0] mode);
		case (mode)
			4'h1: aac_route_decode = aac_route_t'(4'h8);
			4'h2: aac_route_decode = aac_route_t'(4'h2);
			4'h3: aac_route_decode = aac_route_t'(4'h4);
			4'h4: aac_route_decode = aac_route_t'(4'h1);
			4'h5: aac_route_decode = aac_route_t'(4'hc);
			4'h6: aac_route_decode = aac_route_t'(4'h3);
			4'h7: aac_route_decode = aac_route_t'(4'h5);
			4'ha: aac_route_decode = aac_route_t'(4'h6);
			4'he: aac_route_decode = aac_route_t'(4'h7);
			default: aac_route_decode = aac_route_t'(4'h0);
		endcase
	endfunction : aac_route_decode

	// codes past the last step are clamped to it
	function automatic aac_gain_t aac_step_gain(input logic [5:0] code, input logic boost);
		logic [5:0] step;
		step = (code > `AAC_VOL_MAX) ? `AAC_VOL_MAX : code;
		aac_step_gain = AAC_GAIN_QDB[step] + (boost ? `AAC_BOOST_QDB : 10'sh000);
	endfunction : aac_step_gain

endpackage : aac_pkg

// >>> design/aac_if.sv
interface aac_if;
	logic scl_o;
	logic scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;

	// open-drain wires with pull-ups
	assign scl = scl_oe_n | scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport device (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe_n
	);

	modport host (
		input  scl,
		input  sda,
		output scl_o,
		output scl_oe_n,
		output host_sda_o,
		output host_sda_oe_n
	);
endinterface : aac_if

// >>> design/aac_host.sv
`include "aac_cfg.svh"

module aac_host
	import aac_pkg::*;
#(
	parameter int QTR_CYCLES = `AAC_QTR_CYC
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       clk_en,
	input  wire logic       req,
	input  wire logic       strap_level,
	input  wire logic [7:0] ctrl_byte,
	output logic            ready,
	output logic            done,
	output logic            acked,
	aac_if.host             bus
);

	localparam int DW = $clog2(QTR_CYCLES + 1);
	localparam logic [DW-1:0] DIV_LAST = DW'(QTR_CYCLES - 1);

	aac_host_state_t hst_r, hst_nxt;
	logic [DW-1:0]   div_r, div_nxt;
	logic [1:0]      ph_r, ph_nxt;
	logic [3:0]      bit_r, bit_nxt;
	logic [7:0]      sh_r, sh_nxt;
	logic [7:0]      ctl_r, ctl_nxt;
	logic            byte_r, byte_nxt;
	logic            scl_r, scl_nxt;
	logic            sdl_r, sdl_nxt;
	logic            nack_r, nack_nxt;
	logic            done_r, done_nxt;
	logic            acked_r, acked_nxt;
	logic            sda_s1, sda_s2;
	logic            tick;

	assign tick = (div_r == DIV_LAST);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else if (clk_en) begin
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
		end
	end

	always_comb begin
		hst_nxt = hst_r;
		div_nxt = (hst_r == aac_h_idle || tick) ? '0 : div_r + DW'(1);
		ph_nxt = ph_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		ctl_nxt = ctl_r;
		byte_nxt = byte_r;
		scl_nxt = scl_r;
		sdl_nxt = sdl_r;
		nack_nxt = nack_r;
		done_nxt = 1'b0;
		acked_nxt = acked_r;
		if (hst_r == aac_h_idle) begin
			scl_nxt = 1'b1;
			sdl_nxt = 1'b0;
			if (req) begin
				// read bit clear, no data to ack
				sh_nxt = {`AAC_ID_TOP, strap_level, 1'b0};
				ctl_nxt = ctrl_byte;
				nack_nxt = 1'b0;
				ph_nxt = 2'h0;
				hst_nxt = aac_h_start;
			end
		end else if (tick) begin
			ph_nxt = ph_r + 2'h1;
			case (hst_r)
				aac_h_start: begin
					if (ph_r == 2'h0) begin
						sdl_nxt = 1'b1;
					end else begin
						scl_nxt = 1'b0;
						ph_nxt = 2'h0;
						bit_nxt = 4'h0;
						byte_nxt = 1'b0;
						hst_nxt = aac_h_bits;
					end
				end
				aac_h_bits: begin
					case (ph_r)
						// msb first; release on ninth clock
						2'h0: sdl_nxt = (bit_r < `AAC_BITS_PER_BYTE) ? ~sh_r[7] : 1'b0;
						2'h1: scl_nxt = 1'b1;
						2'h2: if (bit_r == `AAC_BITS_PER_BYTE) nack_nxt = sda_s2;
						default: begin
							scl_nxt = 1'b0;
							if (bit_r < `AAC_BITS_PER_BYTE) begin
								sh_nxt = {sh_r[6:0], 1'b0};
								bit_nxt = bit_r + 4'h1;
							end else if (nack_r || byte_r) begin
								hst_nxt = aac_h_stop;
							end else begin
								sh_nxt = ctl_r;
								byte_nxt = 1'b1;
								bit_nxt = 4'h0;
							end
						end
					endcase
				end
				aac_h_stop: begin
					// every frame ends with a stop
					case (ph_r)
						2'h0: sdl_nxt = 1'b1;
						2'h1: scl_nxt = 1'b1;
						2'h2: sdl_nxt = 1'b0;
						default: begin
							done_nxt = 1'b1;
							acked_nxt = ~nack_r;
							hst_nxt = aac_h_idle;
						end
					endcase
				end
				default: hst_nxt = aac_h_idle;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hst_r <= aac_h_idle;
			div_r <= '0;
			ph_r <= 2'h0;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			ctl_r <= 8'h00;
			byte_r <= 1'b0;
			scl_r <= 1'b1;
			sdl_r <= 1'b0;
			nack_r <= 1'b0;
			done_r <= 1'b0;
			acked_r <= 1'b0;
		end else if (clk_en) begin
			hst_r <= hst_nxt;
			div_r <= div_nxt;
			ph_r <= ph_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			ctl_r <= ctl_nxt;
			byte_r <= byte_nxt;
			scl_r <= scl_nxt;
			sdl_r <= sdl_nxt;
			nack_r <= nack_nxt;
			done_r <= done_nxt;
			acked_r <= acked_nxt;
		end
	end

	assign ready = (hst_r == aac_h_idle);
	assign done = done_r;
	assign acked = acked_r;
	assign bus.scl_o = 1'b0;
	assign bus.scl_oe_n = scl_r;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe_n = ~sdl_r;

endmodule : aac_host

// >>> design/aac_device.sv
`include "aac_cfg.svh"

// What this block does
// - slave only, never drives serial clock
// - bytes travel most significant bit first
// - master changes data only while clock low
// - data driver released after power-up
// - ignore bus until start, not while powering
// - stop returns interface to standby
// - transmitter releases, receiver acks ninth clock
// - ack matching identity, address and data bytes
// - master acks each byte it reads
// - identity byte 111110, strap, then zero
// - top bits of control byte select register
// - boost bits add 3 dB per path
// - bit three closes the bypass switch
// - mode field selects output routing
// - mode resets to shutdown
// - each path gain from its volume code
// - 41 volume steps, -82 to 18 dB
// - wake-up interval after leaving shutdown
module aac_device
	import aac_pkg::*;
#(
	parameter int WAKE_CYCLES    = `AAC_WAKE_CYC,
	parameter int POWERUP_CYCLES = `AAC_POWERUP_CYC
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       clk_en,
	input  wire logic       address_select_strap,
	aac_if.device           bus,
	output logic [3:0]      route_sel,
	output logic            bypass_switch_on,
	output logic            speaker_gain_boost,
	output logic            left_phone_gain_boost,
	output logic            right_phone_gain_boost,
	output logic [5:0]      speaker_volume_code,
	output logic [5:0]      left_volume_code,
	output logic [5:0]      right_volume_code,
	output aac_gain_t       speaker_path_gain,
	output aac_gain_t       left_path_gain,
	output aac_gain_t       right_path_gain,
	output logic            speaker_output_off,
	output logic            left_output_off,
	output logic            right_output_off,
	output logic            outputs_ready
);

	localparam int WW = $clog2(WAKE_CYCLES + 1);
	localparam int PW = $clog2(POWERUP_CYCLES + 1);
	localparam logic [WW-1:0] WAKE_LOAD = WW'(WAKE_CYCLES);
	localparam logic [PW-1:0] PWR_DONE  = PW'(POWERUP_CYCLES);

	logic            scl_s1, scl_s2, scl_s3;
	logic            sda_s1, sda_s2, sda_s3;
	logic            strap_s1, strap_s2;
	logic            scl_rise, scl_fall, start_ev, stop_ev, powered, byte_done, id_ok;

	aac_dev_state_t  st_r, st_nxt;
	logic [3:0]      cnt_r, cnt_nxt;
	logic [7:0]      sh_r, sh_nxt;
	logic            drv_r, drv_nxt;
	logic [PW-1:0]   pwr_r, pwr_nxt;

	logic [3:0]      mode_r, mode_nxt;
	logic            byp_r, byp_nxt;
	logic [2:0]      gb_r, gb_nxt;
	logic [5:0]      mvc_r, mvc_nxt, lvc_r, lvc_nxt, rvc_r, rvc_nxt;

	aac_route_t      route_r, route_nxt;
	logic [WW-1:0]   wake_r, wake_nxt;
	aac_gain_t       gm_r, gm_nxt, gl_r, gl_nxt, gr_r, gr_nxt;

	// first stages feed only the second stages
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
			strap_s1 <= 1'b0;
			strap_s2 <= 1'b0;
		end else if (clk_en) begin
			scl_s1 <= bus.scl;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
			strap_s1 <= address_select_strap;
			strap_s2 <= strap_s1;
		end
	end

	assign scl_rise = scl_s2 & ~scl_s3;
	assign scl_fall = ~scl_s2 & scl_s3;
	// data edges under high clock are frame marks
	assign start_ev = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	assign stop_ev  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
	assign powered  = (pwr_r == PWR_DONE);
	assign id_ok    = (sh_r == {`AAC_ID_TOP, strap_s2, 1'b0});
	// a control byte lands only when its ack ends
	assign byte_done = (st_r == aac_ack_byte) && scl_fall && !stop_ev && !start_ev;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		drv_nxt = drv_r;
		pwr_nxt = powered ? pwr_r : pwr_r + PW'(1);
		if (stop_ev) begin
			st_nxt = aac_idle;
			drv_nxt = 1'b0;
		end else if (start_ev && powered) begin
			// a start is the only way in
			st_nxt = aac_rx_id;
			cnt_nxt = 4'h0;
			drv_nxt = 1'b0;
		end else begin
			case (st_r)
				aac_rx_id, aac_rx_byte: begin
					if (scl_rise && cnt_r < `AAC_BITS_PER_BYTE) begin
						sh_nxt = {sh_r[6:0], sda_s2};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == `AAC_BITS_PER_BYTE) begin
						// ack a matching identity and every following byte
						if (st_r == aac_rx_byte || id_ok) begin
							st_nxt = (st_r == aac_rx_id) ? aac_ack_id : aac_ack_byte;
							drv_nxt = 1'b1;
						end else begin
							st_nxt = aac_ignore;
						end
					end
				end
				aac_ack_id, aac_ack_byte: begin
					// hold low through the ninth clock
					if (scl_fall) begin
						drv_nxt = 1'b0;
						cnt_nxt = 4'h0;
						st_nxt = aac_rx_byte;
					end
				end
				aac_idle, aac_ignore: st_nxt = st_r;
				default: st_nxt = aac_idle;
			endcase
		end
	end

	always_comb begin
		mode_nxt = mode_r;
		byp_nxt = byp_r;
		gb_nxt = gb_r;
		mvc_nxt = mvc_r;
		lvc_nxt = lvc_r;
		rvc_nxt = rvc_r;
		if (byte_done) begin
			// register select from the top bits
			case (sh_r[7:5])
				`AAC_SEL_MODE_A, `AAC_SEL_MODE_B: mode_nxt = sh_r[3:0];
				`AAC_SEL_BOOST: begin
					byp_nxt = sh_r[`AAC_BYP_BIT];
					gb_nxt = sh_r[`AAC_GBM_BIT:`AAC_GBR_BIT];
				end
				`AAC_SEL_MVOL: mvc_nxt[4:0] = sh_r[4:0];
				`AAC_SEL_EXT: begin
					if (sh_r[4:3] == 2'h0) begin
						rvc_nxt[5] = sh_r[2];
						lvc_nxt[5] = sh_r[1];
						mvc_nxt[5] = sh_r[0];
					end
				end
				`AAC_SEL_LVOL: lvc_nxt[4:0] = sh_r[4:0];
				`AAC_SEL_RVOL: rvc_nxt[4:0] = sh_r[4:0];
				default: mode_nxt = mode_r;
			endcase
		end
	end

	always_comb begin
		route_nxt = aac_route_decode(mode_r);
		// wake-up count restarts on leaving shutdown
		if (route_nxt == aac_route_t'(4'h0)) begin
			wake_nxt = '0;
		end else if (route_r == aac_route_t'(4'h0)) begin
			wake_nxt = WAKE_LOAD;
		end else if (wake_r != '0) begin
			wake_nxt = wake_r - WW'(1);
		end else begin
			wake_nxt = wake_r;
		end
		gm_nxt = aac_step_gain(mvc_r, gb_r[`AAC_GBM_BIT]);
		gl_nxt = aac_step_gain(lvc_r, gb_r[`AAC_GBL_BIT]);
		gr_nxt = aac_step_gain(rvc_r, gb_r[`AAC_GBR_BIT]);
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_r <= aac_idle;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			drv_r <= 1'b0;
			pwr_r <= '0;
			mode_r <= `AAC_MODE_RST;
			byp_r <= `AAC_FLAG_RST;
			gb_r <= 3'h0;
			mvc_r <= `AAC_VOL_RST;
			lvc_r <= `AAC_VOL_RST;
			rvc_r <= `AAC_VOL_RST;
			route_r <= aac_route_t'(4'h0);
			wake_r <= '0;
			gm_r <= AAC_GAIN_QDB[0];
			gl_r <= AAC_GAIN_QDB[0];
			gr_r <= AAC_GAIN_QDB[0];
		end else if (clk_en) begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			drv_r <= drv_nxt;
			pwr_r <= pwr_nxt;
			mode_r <= mode_nxt;
			byp_r <= byp_nxt;
			gb_r <= gb_nxt;
			mvc_r <= mvc_nxt;
			lvc_r <= lvc_nxt;
			rvc_r <= rvc_nxt;
			route_r <= route_nxt;
			wake_r <= wake_nxt;
			gm_r <= gm_nxt;
			gl_r <= gl_nxt;
			gr_r <= gr_nxt;
		end
	end

	assign route_sel = mode_r;
	assign bypass_switch_on = byp_r;
	assign speaker_gain_boost = gb_r[`AAC_GBM_BIT];
	assign left_phone_gain_boost = gb_r[`AAC_GBL_BIT];
	assign right_phone_gain_boost = gb_r[`AAC_GBR_BIT];
	assign speaker_volume_code = mvc_r;
	assign left_volume_code = lvc_r;
	assign right_volume_code = rvc_r;
	assign speaker_path_gain = gm_r;
	assign left_path_gain = gl_r;
	assign right_path_gain = gr_r;
	assign outputs_ready = (route_r != aac_route_t'(4'h0)) && (wake_r == '0);
	assign speaker_output_off = ~(outputs_ready & (route_r.spk_mono | route_r.spk_stereo));
	assign left_output_off = ~(outputs_ready & (route_r.hp_mono | route_r.hp_stereo));
	assign right_output_off = left_output_off;
	// only data is ever pulled; clock is input only
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe_n = ~drv_r;

endmodule : aac_device

// >>> tb/aac_link_assertions.sv
module aac_link_assertions (
	input	wire logic	clock,
	input	wire logic	nrst,
	input	wire logic	scl_o,
	input	wire logic	scl_oe_n,
	input	wire logic	host_sda_o,
	input	wire logic	host_sda_oe_n,
	input	wire logic	dev_sda_o,
	input	wire logic	dev_sda_oe_n,
	input	wire logic	scl,
	input	wire logic	sda
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	sequence s_start;
		$fell(sda) && scl;
	endsequence
	sequence s_stop;
		$rose(sda) && scl;
	endsequence
	sequence s_ack_on;
		$fell(dev_sda_oe_n);
	endsequence

	chk_rst_release: assert property ($rose(nrst) |-> dev_sda_oe_n [*8])
		else $error("device data driver active after reset");
	chk_dev_pull_only: assert property (!dev_sda_oe_n |-> !dev_sda_o)
		else $error("device drives data high");
	chk_host_pull_only: assert property ((scl_oe_n || !scl_o) && (host_sda_oe_n || !host_sda_o))
		else $error("host drives a line high");
	chk_ack_scl_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("device data changed while clock high");
	chk_ack_held: assert property ($rose(scl) && !dev_sda_oe_n |-> (!dev_sda_oe_n && !sda) [*8])
		else $error("acknowledge not held through clock high");
	chk_ack_bounded: assert property (s_ack_on |-> ##[30:50] $rose(dev_sda_oe_n))
		else $error("acknowledge length wrong");
	chk_start_clocks: assert property (s_start |-> dev_sda_oe_n ##[5:15] $fell(scl))
		else $error("start not followed by clock low");
	chk_stop_idle: assert property (s_stop |-> (scl && sda && dev_sda_oe_n) [*8])
		else $error("bus not idle after stop");
	chk_data_scl_low: assert property (scl && $past(scl) && $changed(host_sda_oe_n) |-> s_start or s_stop)
		else $error("host data changed while clock high");
endmodule : aac_link_assertions

// >>> tb/audio_amp_i2c_control_tb.sv
module audio_amp_i2c_control_tb
	import aac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// short wake count keeps the run small; the real one is 3.5 ms
	localparam int WAKE = 200;

	logic		clock = 1'b0;
	logic		nrst;
	logic		clk_en;
	logic		req;
	logic		strap_level;
	logic		address_select_strap;
	logic [7:0]	ctrl_byte;
	logic		ready;
	logic		done;
	logic		acked;
	logic [3:0]	route_sel;
	logic		bypass_switch_on;
	logic		speaker_gain_boost;
	logic		left_phone_gain_boost;
	logic		right_phone_gain_boost;
	logic [5:0]	speaker_volume_code;
	logic [5:0]	left_volume_code;
	logic [5:0]	right_volume_code;
	aac_gain_t	speaker_path_gain;
	aac_gain_t	left_path_gain;
	aac_gain_t	right_path_gain;
	logic		speaker_output_off;
	logic		left_output_off;
	logic		right_output_off;
	logic		outputs_ready;
	logic [18:0]	wire_bits;
	logic		snoop = 1'b0;
	int		n_mismatch = 0;
	int		cmp_count = 0;

	always #10 clock = ~clock;

	aac_if i_aac_if ();

	aac_host #(.QTR_CYCLES(10)) i_aac_host (
		.clock, .nrst, .clk_en, .req, .strap_level, .ctrl_byte, .ready, .done,
		.acked, .bus(i_aac_if.host)
	);

	aac_device #(.WAKE_CYCLES(WAKE), .POWERUP_CYCLES(16)) i_aac_device (
		.clock, .nrst, .clk_en, .address_select_strap, .bus(i_aac_if.device),
		.route_sel, .bypass_switch_on, .speaker_gain_boost, .left_phone_gain_boost,
		.right_phone_gain_boost, .speaker_volume_code, .left_volume_code,
		.right_volume_code, .speaker_path_gain, .left_path_gain, .right_path_gain,
		.speaker_output_off, .left_output_off, .right_output_off, .outputs_ready
	);

	aac_link_assertions i_chk (
		.clock, .nrst, .scl_o(i_aac_if.scl_o), .scl_oe_n(i_aac_if.scl_oe_n),
		.host_sda_o(i_aac_if.host_sda_o), .host_sda_oe_n(i_aac_if.host_sda_oe_n),
		.dev_sda_o(i_aac_if.dev_sda_o), .dev_sda_oe_n(i_aac_if.dev_sda_oe_n),
		.scl(i_aac_if.scl), .sda(i_aac_if.sda)
	);

	// the stop condition also raises the clock, so a frame shifts in 19 bits
	always @(posedge i_aac_if.scl) begin
		if (snoop) begin
			wire_bits <= {wire_bits[17:0], i_aac_if.sda};
		end
	end

	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	task automatic send(input logic [7:0] b);
		int k;
		k = 0;
		while (ready !== 1'b1 && k < 100) begin
			@(negedge clock);
			k++;
		end
		@(negedge clock);
		ctrl_byte = b;
		req = 1'b1;
		@(negedge clock);
		req = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 2000) begin
			@(negedge clock);
			k++;
		end
		if (k == 2000) begin
			n_mismatch++;
			$display("BAD %0t transfer never finished", $time);
		end
	endtask : send

	task automatic t_reset();
		check(10'(route_sel), 10'h000);
		check(10'(i_aac_if.dev_sda_oe_n), 10'h001);
		check(speaker_path_gain, -10'sd328);
		check(10'({speaker_output_off, left_output_off, outputs_ready}), 10'h006);
		check(10'(ready), 10'h001);
		// the device ignores the bus for a while after reset
		repeat (20) @(negedge clock);
	endtask : t_reset

	task automatic t_wake();
		send(8'h00);
		snoop = 1'b1;
		send(8'h01);
		snoop = 1'b0;
		check(10'(wire_bits[18:10]), 10'h1f0);
		check(wire_bits[9:0], 10'h004);
		check(10'({i_aac_if.scl, i_aac_if.sda, i_aac_if.dev_sda_oe_n}), 10'h007);
		check(10'({acked, outputs_ready}), 10'h002);
		repeat (WAKE) @(negedge clock);
		check(10'(outputs_ready), 10'h001);
	endtask : t_wake

	task automatic t_modes();
		logic sp;
		logic hp;
		for (int m = 0; m < 16; m++) begin
			sp = m inside {1, 3, 5, 7, 10, 14};
			hp = m inside {2, 4, 6, 7, 10, 14};
			send({4'h0, 4'(m)});
			check(10'(route_sel), 10'(m));
			// leaving shutdown the outputs stay off until the wake-up count runs out
			repeat (WAKE) @(negedge clock);
			check(10'({speaker_output_off, left_output_off, right_output_off}), 10'({!sp, !hp, !hp}));
		end
		send(8'h27);
		check(10'(route_sel), 10'h007);
	endtask : t_modes

	task automatic t_gain();
		send(8'h6d);
		check(10'({bypass_switch_on, speaker_gain_boost, left_phone_gain_boost, right_phone_gain_boost}), 10'h00d);
		send(8'ha2);
		send(8'h98);
		send(8'hc8);
		send(8'hf1);
		check(10'({left_volume_code, right_volume_code[3:0]}), 10'h281);
		check(speaker_path_gain, 10'sd12);
		check(left_path_gain, 10'sd72);
		check(right_path_gain, -10'sd28);
		send(8'h9f);
		check(speaker_path_gain, 10'sd54);
		check(10'(speaker_volume_code), 10'h01f);
		// reserved selector and extension pattern must be accepted yet ignored
		send(8'hbf);
		send(8'h5f);
		check(10'({acked, left_volume_code}), 10'h068);
		check(10'({route_sel, right_volume_code}), 10'h1d1);
	endtask : t_gain

	task automatic t_ident();
		strap_level = 1'b1;
		send(8'h00);
		check(10'({acked, route_sel}), 10'h007);
		address_select_strap = 1'b1;
		send(8'h00);
		check(10'({acked, route_sel}), 10'h010);
		check(10'({outputs_ready, speaker_output_off}), 10'h001);
	endtask : t_ident

	// power-up window counts enabled cycles only, so a frozen wait does not shorten it
	task automatic t_powerup();
		nrst = 1'b0;
		clk_en = 1'b0;
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		repeat (30) @(negedge clock);
		check(10'({route_sel, bypass_switch_on, right_phone_gain_boost}), 10'h000);
		check(10'(left_volume_code), 10'h000);
		clk_en = 1'b1;
		send(8'h01);
		check(10'({acked, route_sel}), 10'h000);
		send(8'h01);
		check(10'({acked, route_sel}), 10'h011);
	endtask : t_powerup

	initial begin
		#1200000;
		n_mismatch++;
		$display("BAD %0t run timed out", $time);
		wrap_up();
	end

	initial begin
		nrst = 1'b0;
		req = 1'b0;
		ctrl_byte = 8'h00;
		strap_level = 1'b0;
		address_select_strap = 1'b0;
		clk_en = 1'b1;
		repeat (10) @(negedge clock);
		nrst = 1'b1;
		t_reset();
		t_wake();
		t_modes();
		t_gain();
		t_ident();
		t_powerup();
		wrap_up();
	end
endmodule : audio_amp_i2c_control_tb
